// *** hdl/asmc_params.svh ***
`ifndef ASMC_PARAMS_SVH
`define ASMC_PARAMS_SVH

// Stream geometry
`define ASMC_NPATH 4
`define ASMC_SAMP_W 8
`define ASMC_WORD_W 32
`define ASMC_SAMP_PER_WORD 4
`define ASMC_SNAP_SAMPLES 1024
`define ASMC_SNAP_WORDS (`ASMC_SNAP_SAMPLES / `ASMC_SAMP_PER_WORD)
`define ASMC_ADDR_W 8
`define ASMC_PATH_W 2
`define ASMC_LAST_ADDR 8'hFF
`define ASMC_FIFO_DEPTH 8

// Sync interval default, in datapath clock cycles
`define ASMC_SYNC_DEF 200000000

// Timing
`define ASMC_CLK_NS 25
`define ASMC_I2C_QTR_NS 2500
`define ASMC_I2C_QTR_CYC ((`ASMC_I2C_QTR_NS + `ASMC_CLK_NS - 1) / `ASMC_CLK_NS)
`define ASMC_QCNT_W 7

// Converter configuration sequence (values arbitrary)
`define ASMC_I2C_DEV_ADDR 8'h40
`define ASMC_I2C_MODE_REG 8'h0D
`define ASMC_I2C_TEST_VAL 8'h01
`define ASMC_I2C_NORM_VAL 8'h00
`define ASMC_I2C_FRAME_BITS 27
`define ASMC_I2C_BITCNT_W 5

// Error counter
`define ASMC_ERRCNT_W 16

`endif

// *** hdl/asmc_pkg.sv ***
package asmc_pkg;
`include "asmc_params.svh"

    typedef logic [`ASMC_SAMP_W-1:0] asmc_sample_t;

    // One datapath word per path: four samples, oldest in the low byte
    typedef struct packed {
        logic [`ASMC_NPATH-1:0][`ASMC_SAMP_PER_WORD-1:0][`ASMC_SAMP_W-1:0] path;
    } asmc_frame_t;

    // Open-drain drive of the configuration bus
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } asmc_i2c_out_t;

    typedef enum logic [1:0] {
        I2C_IDLE,
        I2C_START,
        I2C_BIT,
        I2C_STOP
    } asmc_i2c_st_t;

    typedef logic [`ASMC_NPATH-1:0][`ASMC_ERRCNT_W-1:0] asmc_errcnt_t;
endpackage

// *** hdl/asmc_fifo.sv ***
`timescale 1ns/1ps
module asmc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign in_ready = (cnt_q != CW'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Pointers wrap at depth
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
            end
        end
    end

    // Fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// *** hdl/asmc_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// RL1 - Snapshot holds 1024 samples per signal path
// RL2 - Buffer fill begins on internal sync pulse
// RL3 - Every sync pulse refreshes the snapshot
// RL4 - Sync interval programmable in clock cycles
// RL5 - External PPS starts the periodic sync sequence
// RL6 - Continuous bit-exact check against test pattern
// RL7 - Drive I2C to select test or normal mode
// RL8 - Controls and results exposed to software
// RL9 - Four 8-bit samples packed per 32-bit word
// RL10 - All logic runs in the datapath clock
// RL11 - Full snapshot held until next sync
`include "asmc_params.svh"
module asmc_top #(
    parameter logic [31:0] SYNC_INTERVAL_DEF = 32'(`ASMC_SYNC_DEF)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire asmc_pkg::asmc_frame_t link_data,
    output logic link_overflow,
    input wire logic sink_ready,
    input wire logic pps,
    input wire logic sync_en,
    input wire logic [31:0] sync_interval,
    output logic sync_pulse,
    input wire logic rd_en,
    input wire logic [`ASMC_PATH_W-1:0] rd_path,
    input wire logic [`ASMC_ADDR_W-1:0] rd_addr,
    output logic [`ASMC_WORD_W-1:0] rd_data,
    output logic rd_valid,
    output logic capture_busy,
    output logic capture_done,
    input wire logic chk_en,
    input wire logic chk_clr,
    output logic [`ASMC_NPATH-1:0] chk_err,
    output asmc_pkg::asmc_errcnt_t chk_err_cnt,
    input wire logic cfg_go,
    input wire logic cfg_test_mode,
    output logic cfg_busy,
    output logic cfg_nack,
    input wire logic scl_i,
    input wire logic sda_i,
    output asmc_pkg::asmc_i2c_out_t i2c_out
);
    import asmc_pkg::*;

    // Samples in one path word that break the running ramp
    function automatic logic word_bad(input logic [3:0][7:0] w, input asmc_sample_t e);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < `ASMC_SAMP_PER_WORD; i++) begin
            bad = bad | (w[i] != asmc_sample_t'(e + 8'(i)));
        end
        return bad;
    endfunction

    // Link, PPS and I2C pin synchronisers
    logic lclk_s1_q, lclk_s2_q, lclk_s3_q;
    asmc_frame_t ldat_s1_q, ldat_s2_q;
    logic pps_s1_q, pps_s2_q, pps_s3_q;
    logic sda_s1_q, sda_s2_q;
    logic scl_s1_q, scl_s2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            {lclk_s1_q, lclk_s2_q, lclk_s3_q} <= 3'h0;
            {pps_s1_q, pps_s2_q, pps_s3_q} <= 3'h0;
            {sda_s1_q, sda_s2_q, scl_s1_q, scl_s2_q} <= 4'hF;
            ldat_s1_q <= '0;
            ldat_s2_q <= '0;
        end else begin
            {lclk_s3_q, lclk_s2_q, lclk_s1_q} <= {lclk_s2_q, lclk_s1_q, link_clk};
            {pps_s3_q, pps_s2_q, pps_s1_q} <= {pps_s2_q, pps_s1_q, pps};
            {sda_s2_q, sda_s1_q} <= {sda_s1_q, sda_i};
            {scl_s2_q, scl_s1_q} <= {scl_s1_q, scl_i};
            ldat_s1_q <= link_data;
            ldat_s2_q <= ldat_s1_q;
        end
    end

    logic lclk_rise, pps_rise;
    assign lclk_rise = lclk_s2_q && !lclk_s3_q;
    assign pps_rise = pps_s2_q && !pps_s3_q;

    // Link words enter the FIFO; sink stalls back-pressure it
    logic fifo_in_ready, word_v;
    asmc_frame_t word;
    asmc_fifo #(.W($bits(asmc_frame_t)), .D(`ASMC_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(lclk_rise),
        .in_ready(fifo_in_ready),
        .in_data(ldat_s2_q),
        .out_valid(word_v),
        .out_ready(sink_ready),
        .out_data(word)
    );
    logic word_take;
    assign word_take = word_v && sink_ready; // RL9 RL10

    // Lost link word while full, sticky until reset
    logic ovf_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (lclk_rise && !fifo_in_ready) begin
            ovf_q <= 1'b1;
        end
    end
    assign link_overflow = ovf_q;

    // Sync sequencer, restarted by PPS
    logic run_q, sync_q;
    logic [31:0] scnt_q, ivl;
    assign ivl = (sync_interval == 32'h0) ? SYNC_INTERVAL_DEF : sync_interval;
    always_ff @(posedge clk) begin
        if (rst || !sync_en) begin
            run_q <= 1'b0;
            scnt_q <= '0;
            sync_q <= 1'b0;
        end else if (pps_rise) begin
            run_q <= 1'b1; // RL5
            scnt_q <= '0;
            sync_q <= 1'b1;
        end else if (run_q && scnt_q == ivl - 32'h1) begin
            scnt_q <= '0; // RL4
            sync_q <= 1'b1;
        end else begin
            scnt_q <= run_q ? scnt_q + 32'h1 : scnt_q;
            sync_q <= 1'b0;
        end
    end
    assign sync_pulse = sync_q;

    // Capture control
    logic cap_q, done_q, we;
    logic [`ASMC_ADDR_W-1:0] waddr_q, wa;
    assign wa = sync_q ? '0 : waddr_q; // RL2
    assign we = word_take && (sync_q || cap_q); // RL11
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_q <= 1'b0;
            done_q <= 1'b0;
            waddr_q <= '0;
        end else begin
            if (sync_q) begin
                cap_q <= 1'b1; // RL3
                done_q <= 1'b0;
                waddr_q <= '0;
            end
            if (we) begin
                waddr_q <= wa + 1'b1;
                if (wa == `ASMC_LAST_ADDR) begin
                    cap_q <= 1'b0; // RL1
                    done_q <= 1'b1;
                end
            end
        end
    end
    assign capture_busy = cap_q;
    assign capture_done = done_q;

    // Snapshot memory, one line holds all paths
    asmc_frame_t snap_mem [`ASMC_SNAP_WORDS];
    always_ff @(posedge clk) begin
        if (we) begin
            snap_mem[wa] <= word;
        end
    end

    // Registered read port
    logic [`ASMC_WORD_W-1:0] rd_data_q;
    logic rd_valid_q;
    asmc_frame_t rd_line;
    assign rd_line = snap_mem[rd_addr];
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en; // RL8
            if (rd_en) begin
                rd_data_q <= rd_line.path[rd_path];
            end
        end
    end
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;

    // Pattern checker: each path is a ramp, four steps per word
    logic [`ASMC_NPATH-1:0] lock_q, err_q, bad;
    asmc_sample_t exp_q [`ASMC_NPATH];
    asmc_errcnt_t ecnt_q;
    always_comb begin
        for (int p = 0; p < `ASMC_NPATH; p++) begin
            bad[p] = word_take && chk_en && lock_q[p] && word_bad(word.path[p], exp_q[p]);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q <= '0;
            err_q <= '0;
            ecnt_q <= '0;
            for (int p = 0; p < `ASMC_NPATH; p++) begin
                exp_q[p] <= '0;
            end
        end else begin
            for (int p = 0; p < `ASMC_NPATH; p++) begin
                err_q[p] <= bad[p] || (err_q[p] && !chk_clr); // RL6
                if (chk_clr) begin
                    ecnt_q[p] <= {{(`ASMC_ERRCNT_W-1){1'b0}}, bad[p]};
                end else if (bad[p] && ecnt_q[p] != '1) begin
                    ecnt_q[p] <= ecnt_q[p] + 1'b1; // RL6
                end
                if (chk_clr || !chk_en) begin
                    lock_q[p] <= 1'b0;
                end else if (word_take) begin
                    lock_q[p] <= 1'b1;
                    exp_q[p] <= lock_q[p] ? exp_q[p] + 8'h04 : word.path[p][3] + 8'h01;
                end
            end
        end
    end
    assign chk_err = err_q;
    assign chk_err_cnt = ecnt_q;

    // Converter mode writer over open-drain I2C
    asmc_i2c_st_t st_q;
    logic [`ASMC_QCNT_W-1:0] qcnt_q;
    logic [1:0] ph_q;
    logic [`ASMC_I2C_BITCNT_W-1:0] bit_q;
    logic [`ASMC_I2C_FRAME_BITS-1:0] sh_q;
    logic scl_oe_q, sda_oe_q, nack_q, tick, ack_slot;
    assign tick = (qcnt_q == `ASMC_QCNT_W'(`ASMC_I2C_QTR_CYC - 1));
    assign ack_slot = (bit_q == 5'd8) || (bit_q == 5'd17) || (bit_q == 5'd26);
    always_ff @(posedge clk) begin
        if (rst || st_q == I2C_IDLE || tick) begin
            qcnt_q <= '0;
        end else begin
            qcnt_q <= qcnt_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= I2C_IDLE;
            ph_q <= 2'h0;
            bit_q <= '0;
            sh_q <= '0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            case (st_q)
                I2C_IDLE: begin
                    ph_q <= 2'h0;
                    if (cfg_go) begin
                        st_q <= I2C_START; // RL7
                        bit_q <= '0;
                        nack_q <= 1'b0;
                        sh_q <= {`ASMC_I2C_DEV_ADDR, 1'b1, `ASMC_I2C_MODE_REG, 1'b1,
                                 cfg_test_mode ? `ASMC_I2C_TEST_VAL : `ASMC_I2C_NORM_VAL,
                                 1'b1};
                    end
                end
                I2C_START: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) begin
                            sda_oe_q <= 1'b1;
                        end else begin
                            scl_oe_q <= 1'b1;
                            ph_q <= 2'h0;
                            st_q <= I2C_BIT;
                        end
                    end
                end
                I2C_BIT: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_oe_q <= !sh_q[`ASMC_I2C_FRAME_BITS-1]; // RL7
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: nack_q <= nack_q || (ack_slot && scl_s2_q && sda_s2_q);
                            default: begin
                                scl_oe_q <= 1'b1;
                                sh_q <= {sh_q[`ASMC_I2C_FRAME_BITS-2:0], 1'b1};
                                bit_q <= bit_q + 1'b1;
                                if (bit_q == 5'(`ASMC_I2C_FRAME_BITS - 1)) begin
                                    st_q <= I2C_STOP;
                                end
                            end
                        endcase
                    end
                end
                I2C_STOP: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            default: begin
                                sda_oe_q <= 1'b0;
                                st_q <= I2C_IDLE;
                            end
                        endcase
                    end
                end
                default: st_q <= I2C_IDLE;
            endcase
        end
    end
    assign i2c_out = '{scl_o: 1'b0, scl_oe: scl_oe_q, sda_o: 1'b0, sda_oe: sda_oe_q};
    assign cfg_busy = (st_q != I2C_IDLE);
    assign cfg_nack = nack_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pps_sync_start: assert property (pps_rise && sync_en |=> sync_q) // RL5
        else $error("pps did not start sync");
    a_sync_period: assert property (
        sync_en && run_q && !pps_rise && scnt_q == ivl - 32'h1 ##1 sync_en |-> sync_q) // RL4
        else $error("sync interval missed");
    a_sync_single: assert property (sync_q && sync_en && !pps_rise && ivl > 32'h1 |=> !sync_q)
        else $error("sync wider than one cycle"); // RL4
    a_capture_restart: assert property (sync_q |=> cap_q && !done_q) // RL3
        else $error("sync did not restart capture");
    a_capture_len: assert property (we && wa == `ASMC_LAST_ADDR && !sync_q |=> done_q && !cap_q)
        else $error("capture length wrong"); // RL1
    a_fill_start: assert property (sync_q |=> waddr_q == {7'h0, $past(word_take)}) // RL2
        else $error("fill not at address zero");
    a_hold_frozen: assert property (done_q && !sync_q |-> !we) // RL11
        else $error("snapshot changed while held");
    a_err_count: assert property (
        bad[0] && !chk_clr && ecnt_q[0] != '1 |=> ecnt_q[0] == $past(ecnt_q[0]) + 1'b1) // RL6
        else $error("error count not advanced");
    a_err_sticky: assert property (bad[0] |=> err_q[0] [*2] or (err_q[0] ##1 1'b1)) // RL6
        else $error("error flag lost");
    a_rd_latency: assert property (rd_en |=> rd_valid_q && rd_data_q == $past(rd_line.path[rd_path]))
        else $error("read data late"); // RL8
    a_cfg_start: assert property (!cfg_busy && cfg_go |=> cfg_busy ##[1:200] sda_oe_q) // RL7
        else $error("i2c start not driven");

    c_sync_seen: cover property (run_q && sync_q && $past(run_q));
    c_full_capture: cover property ($rose(done_q));
    c_bist_error: cover property (bad != '0);
    c_cfg_frame: cover property ($fell(cfg_busy));
endmodule

// *** verif/asmc_adc_model.sv ***
`timescale 1ns/1ps
// Converter side: ramp words on the link and a configuration bus responder
module asmc_adc_model (
    input wire logic run,
    input wire logic err,
    input wire logic [1:0] err_path,
    input wire logic ack_en,
    input wire logic scl,
    input wire logic sda,
    output logic link_clk,
    output asmc_pkg::asmc_frame_t link_data,
    output logic sda_oe
);
    import asmc_pkg::*;
    int w = 0;
    int n = 0;
    logic ack_q = 1'b0;

    // Acknowledge pull-down towards the bus
    assign sda_oe = ack_q;

    // Link clock toggles only while a run is open, 200 ns period
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #100 link_clk = run ? ~link_clk : 1'b0;
    end

    // Next word on each falling link edge, stable across the rising edge
    always @(negedge link_clk) begin
        w <= w + 1;
    end

    // Ramp per path, path offset 64, one flipped bit while err is high
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 4; i++) begin
                link_data.path[p][i] = 8'(w * 4 + i + p * 64) ^ 8'(err && p == err_path && i == 0);
            end
        end
    end

    // Start condition restarts the count of clock falls
    always @(negedge sda) begin
        if (scl) begin
            n = 0;
        end
    end

    // Data pulled low for the ninth bit of each byte when acking
    always @(negedge scl) begin
        n = n + 1;
        ack_q = ack_en && (n == 9 || n == 18 || n == 27);
    end
endmodule

// *** verif/adc_sample_monitor_capture_bench.sv ***
`timescale 1ns/1ps
module adc_sample_monitor_capture_bench;
    import asmc_pkg::*;
`include "asmc_params.svh"
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pps = 1'b0;
    logic sync_en = 1'b0;
    logic [31:0] sync_interval = 32'h00000BB8;
    logic rd_en = 1'b0;
    logic [1:0] rd_path = 2'h0;
    logic [7:0] rd_addr = 8'h00;
    logic chk_en = 1'b0;
    logic chk_clr = 1'b0;
    logic cfg_go = 1'b0;
    logic cfg_test_mode = 1'b0;
    logic sink_ready = 1'b1;
    logic run = 1'b0;
    logic err = 1'b0;
    logic [1:0] err_path = 2'h0;
    logic ack_en = 1'b1;
    logic link_clk, link_overflow, sync_pulse, rd_valid, capture_busy, capture_done;
    logic cfg_busy, cfg_nack, model_sda_oe, scl_w, sda_w;
    logic [31:0] rd_data;
    logic [3:0] chk_err;
    asmc_frame_t link_data;
    asmc_errcnt_t chk_err_cnt;
    asmc_i2c_out_t i2c_out;
    logic [31:0] s1, d, e;
    logic [31:0] rnd = 32'h00000026;
    logic [26:0] fr;
    logic bits[$];
    int n;
    localparam int DEF_IVL = 500;
    int fail_count = 0;
    int check_count = 0;

    // Open-drain lines with pull-ups
    assign scl_w = ~i2c_out.scl_oe;
    assign sda_w = ~(i2c_out.sda_oe | model_sda_oe);

    always #12.5 clk = ~clk;

    asmc_top #(.SYNC_INTERVAL_DEF(32'(DEF_IVL))) dut (.clk(clk), .rst(rst),
        .link_clk(link_clk), .link_data(link_data),
        .link_overflow(link_overflow), .sink_ready(sink_ready), .pps(pps), .sync_en(sync_en),
        .sync_interval(sync_interval), .sync_pulse(sync_pulse), .rd_en(rd_en),
        .rd_path(rd_path), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .capture_busy(capture_busy), .capture_done(capture_done), .chk_en(chk_en),
        .chk_clr(chk_clr), .chk_err(chk_err), .chk_err_cnt(chk_err_cnt), .cfg_go(cfg_go),
        .cfg_test_mode(cfg_test_mode), .cfg_busy(cfg_busy), .cfg_nack(cfg_nack),
        .scl_i(scl_w), .sda_i(sda_w), .i2c_out(i2c_out));

    asmc_adc_model adc (.run(run), .err(err), .err_path(err_path), .ack_en(ack_en),
        .scl(scl_w), .sda(sda_w), .link_clk(link_clk), .link_data(link_data),
        .sda_oe(model_sda_oe));

    // Bits seen on the bus at each clock rise during a frame
    always @(posedge scl_w) begin
        if (cfg_busy === 1'b1) begin
            bits.push_back(sda_w);
        end
    end

    function automatic logic [31:0] next_rand(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // One read; rd_en stays high so reads can run back to back
    task automatic rd(input int p, input int a, output logic [31:0] q);
        rd_en = 1'b1;
        rd_path = 2'(p);
        rd_addr = 8'(a);
        @(negedge clk);
        check_val(32'(rd_valid), 32'h1);
        q = rd_data;
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #(60000 * 25);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

    // Main sequence
    initial begin
        cyc(2);
        rst = 1'b0;
        check_val({20'h0, i2c_out.scl_oe, i2c_out.sda_oe, chk_err, sync_pulse, capture_done,
            capture_busy, link_overflow, cfg_busy, cfg_nack}, 32'h0);
        check_val(rd_data, 32'h0);
        $display("Test reset done");
        run = 1'b1;
        sync_en = 1'b1;
        cyc(20);
        pps = 1'b1;
        n = 0;
        while (sync_pulse !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check_val(32'(n < 7), 32'h1);
        cyc(1);
        check_val(32'({capture_busy, capture_done}), 32'h2);
        cyc(2199);
        check_val(32'({capture_busy, capture_done}), 32'h1);
        rd(0, 0, s1);
        rd_en = 1'b0;
        n = 2201;
        while (sync_pulse !== 1'b1 && n < 3500) begin
            @(negedge clk);
            n++;
        end
        check_cnt(n, 3000);
        cyc(2200);
        sync_en = 1'b0;
        // Second capture is 375 link words on, so 1500 samples later
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 256; k++) begin
                rd(p, k, d);
                for (int i = 0; i < 4; i++) begin
                    e[8 * i +: 8] = 8'(s1[7:0] + 1500 + p * 64 + 4 * k + i);
                end
                check_val(d, e);
            end
        end
        rd_en = 1'b0;
        cyc(300);
        rd(0, 0, d);
        rd_en = 1'b0;
        check_val(d, {8'(s1[7:0] + 1503), 8'(s1[7:0] + 1502), 8'(s1[7:0] + 1501),
            8'(s1[7:0] + 1500)});
        check_val(32'(capture_done), 32'h1);
        $display("Test capture done");
        chk_en = 1'b1;
        chk_clr = 1'b1;
        @(negedge clk);
        chk_clr = 1'b0;
        for (int j = 0; j < 400; j++) begin
            rnd = next_rand(rnd);
            sink_ready = (rnd[1:0] != 2'h0);
            @(negedge clk);
        end
        sink_ready = 1'b1;
        check_val({28'h0, chk_err}, 32'h0);
        // One corrupted word on every path, random first path
        rnd = next_rand(rnd);
        e = 32'h0;
        for (int q = 0; q < 4; q++) begin
            err_path = 2'(rnd[1:0] + 2'(q));
            @(negedge link_clk);
            #1 err = 1'b1;
            @(negedge link_clk);
            #1 err = 1'b0;
            cyc(40);
            e = e | (32'h1 << err_path);
            check_val({28'h0, chk_err}, e);
            check_val(32'(chk_err_cnt[err_path]), 32'h1);
        end
        chk_clr = 1'b1;
        @(negedge clk);
        chk_clr = 1'b0;
        cyc(20);
        check_val({28'h0, chk_err}, 32'h0);
        $display("Test checker done");
        // Test mode with acks, then normal mode unacknowledged
        for (int t = 1; t >= 0; t--) begin
            ack_en = (t == 1);
            bits.delete();
            cfg_test_mode = 1'(t);
            cfg_go = 1'b1;
            @(negedge clk);
            cfg_go = 1'b0;
            n = 0;
            while (cfg_busy === 1'b1 && n < 15000) begin
                @(negedge clk);
                n++;
            end
            fr = {`ASMC_I2C_DEV_ADDR, !ack_en, `ASMC_I2C_MODE_REG, !ack_en,
                (t == 1) ? `ASMC_I2C_TEST_VAL : `ASMC_I2C_NORM_VAL, !ack_en};
            check_val(32'(bits.size() >= 27), 32'h1);
            for (int b = 0; b < 27 && b < bits.size(); b++) begin
                check_val(32'(bits[b]), 32'(fr[26 - b]));
            end
            check_val(32'(cfg_nack), 32'(t == 0));
        end
        $display("Test configuration done");
        check_val(32'(link_overflow), 32'h0);
        sink_ready = 1'b0;
        cyc(120);
        check_val(32'(link_overflow), 32'h1);
        sink_ready = 1'b1;
        cyc(20);
        $display("Test overflow done");
        // Zero interval selects the default period
        sync_interval = 32'h0;
        pps = 1'b0;
        cyc(5);
        sync_en = 1'b1;
        pps = 1'b1;
        n = 0;
        while (sync_pulse !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check_val(32'(n < 7), 32'h1);
        @(negedge clk);
        n = 1;
        while (sync_pulse !== 1'b1 && n < DEF_IVL + 100) begin
            @(negedge clk);
            n++;
        end
        check_cnt(n, DEF_IVL);
        $display("Test default interval done");
        end_of_test();
    end
endmodule
